// File: rtl/delay_timer.sv
`timescale 1ns/100ps
// Restartable down-counter; done stays high once the count is spent
module delay_timer #(
    parameter logic [laser_seq_pkg::TIMER_W-1:0] CYCLES =
        laser_seq_pkg::TIMER_W'(laser_seq_pkg::ARM_DELAY_CYCLES)
) (
    input wire logic clk,
    input wire logic rstn,
    input wire logic start,
    input wire logic run,
    output logic done
);
    import laser_seq_pkg::*;

    logic [TIMER_W-1:0] count_q; // Cycles still to go

    // Start reloads; the count only advances while run is high
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            count_q <= '0;
            done <= 1'b0;
        end else if (start) begin
            count_q <= CYCLES - TIMER_W'(1);
            done <= 1'b0;
        end else if (run && !done) begin
            if (count_q == '0) begin
                done <= 1'b1;
            end else begin
                count_q <= count_q - TIMER_W'(1);
            end
        end
    end
endmodule : delay_timer

// File: rtl/input_sync.sv
`timescale 1ns/100ps
// Two-flop synchroniser for a group of slow external levels
module input_sync (
    input wire logic clk,
    input wire logic rstn,
    input wire logic [laser_seq_pkg::SYNC_W-1:0] async,
    output logic [laser_seq_pkg::SYNC_W-1:0] synced
);
    import laser_seq_pkg::*;

    logic [SYNC_W-1:0] meta_q; // First stage, read only by second stage

    // Each bit gets its own pair of flops
    for (genvar i = 0; i < SYNC_W; i++) begin : g_bit
        always_ff @(posedge clk or negedge rstn) begin
            if (!rstn) begin
                meta_q[i] <= 1'b0;
                synced[i] <= 1'b0;
            end else begin
                meta_q[i] <= async[i];
                synced[i] <= meta_q[i];
            end
        end
    end
endmodule : input_sync

// File: rtl/laser_enable_sequencer.sv
`timescale 1ns/100ps
// Operation
// - Keyswitch variant needs key off/on after fault
// - Over-temperature latches until power is cycled
// - Reset request pulse acts as a keyswitch toggle
// - Request release powers driver, ready after delay
// - Held reset request keeps driver power off
// - Ready output closed only while lasing possible
// - No driver power without shutter and interlock
// - OEM variant enables at power-up if inputs ok
// - OEM variant does not latch interlock faults
// - OEM reset request is only an immediate inhibit
// - Shutter output needs switch open and request
// - Interlock removal cuts power and drops ready
module laser_enable_sequencer #(
    parameter int unsigned DELAY_CYCLES = laser_seq_pkg::ARM_DELAY_CYCLES
) (
    input wire logic clk,
    input wire logic rstn,
    // APB slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // Static variant strap, 1 selects OEM behaviour
    input wire logic oemMode,
    // Operator and machine inputs, all asynchronous levels
    input wire logic keyOn,
    input wire logic resetRequest,
    input wire logic shutterSwitchOpen,
    input wire logic shutterRequest,
    input wire logic interlockClosed,
    input wire logic overTemp,
    // Outputs to the RF driver supply and status switches
    output logic rfPowerEn,
    output logic readyClosed,
    output logic readyLamp,
    output logic shutterClosed,
    output logic shutter_lamp,
    output logic interlockOpenClosed,
    output logic irq
);
    import laser_seq_pkg::*;

    ////////////////////////////////////////////////////////////////////////
    // Input synchronisation

    logic [SYNC_W-1:0] rawIn; // Asynchronous input bundle
    logic [SYNC_W-1:0] syncIn; // Same bundle in the clk domain
    logic keyOnS; // Keyswitch in ON position
    logic resetReqS; // Remote reset/start request held
    logic shutSwS; // Manual shutter switch open
    logic shutReqS; // Shutter open request present
    logic intlkS; // Remote interlock closed
    logic overTempS; // Over-temperature sensor tripped
    logic oemS; // Variant strap

    assign rawIn = {oemMode, overTemp, interlockClosed, shutterRequest,
                    shutterSwitchOpen, resetRequest, keyOn};

    // Every external level passes two flops before use
    input_sync u_sync (
        .clk(clk),
        .rstn(rstn),
        .async(rawIn),
        .synced(syncIn)
    );

    assign keyOnS = syncIn[0];
    assign resetReqS = syncIn[1];
    assign shutSwS = syncIn[2];
    assign shutReqS = syncIn[3];
    assign intlkS = syncIn[4];
    assign overTempS = syncIn[5];
    assign oemS = syncIn[6];

    ////////////////////////////////////////////////////////////////////////
    // Variant strap capture

    logic oem_q; // Variant held for the whole power cycle
    logic strapTaken_q; // Strap has been sampled once
    logic [1:0] strapAge_q; // Edges since reset, until sync is full

    // Two edges flush the reset zeros out of the synchroniser
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            strapAge_q <= 2'h0;
        end else begin
            strapAge_q <= {strapAge_q[0], 1'b1};
        end
    end

    // Caught once the synchroniser holds real levels, so a wiggling
    // strap cannot switch behaviour half way through a sequence
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            oem_q <= 1'b0;
            strapTaken_q <= 1'b0;
        end else if (!strapTaken_q && strapAge_q[1]) begin
            oem_q <= oemS;
            strapTaken_q <= 1'b1;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Over-temperature latch

    logic otLatch_q; // Cleared only by a power-on reset

    // No software or input path clears this; only rstn does
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            otLatch_q <= 1'b0;
        end else if (overTempS) begin
            otLatch_q <= 1'b1;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Keyswitch-variant sequencer

    seq_state_e state_q; // Sequencer state
    seq_state_e state_d; // Next state
    logic timerStart; // Reload the enable delay
    logic timerDone; // Enable delay has elapsed
    logic resetAction; // Key turned off or request held

    // Key off and request asserted are the same reset action
    assign resetAction = !keyOnS || resetReqS;

    // Next state; interlock loss checked first, over-temperature applied last
    always_comb begin
        state_d = state_q;
        timerStart = 1'b0;
        case (state_q)
            ST_LOCKED: begin
                // Power-up or fault: wait for key toggle or pulse
                if (resetAction) begin
                    state_d = ST_ARMED;
                end
            end
            ST_ARMED: begin
                // Release of the reset action starts the delay
                if (!resetAction && intlkS && !otLatch_q) begin
                    state_d = ST_DELAY;
                    timerStart = 1'b1;
                end
            end
            ST_DELAY: begin
                if (!intlkS) begin
                    state_d = ST_LOCKED;
                end else if (resetAction) begin
                    state_d = ST_ARMED;
                end else if (timerDone) begin
                    state_d = ST_READY;
                end
            end
            ST_READY: begin
                if (!intlkS) begin
                    state_d = ST_LOCKED;
                end else if (resetAction) begin
                    state_d = ST_ARMED;
                end
            end
            default: begin
                state_d = ST_LOCKED;
            end
        endcase
        // Over-temperature forces the latched-off state
        if (otLatch_q) begin
            state_d = ST_LOCKED;
        end
    end

    // State register; idles locked in OEM mode and until the inputs
    // are valid, as reset zeros in the sync would look like key-off
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            state_q <= ST_LOCKED;
        end else if (oem_q || !strapTaken_q) begin
            state_q <= ST_LOCKED;
        end else begin
            state_q <= state_d;
        end
    end

    // Only counts in the delay state, so leaving it freezes the count
    delay_timer #(
        .CYCLES(TIMER_W'(DELAY_CYCLES))
    ) u_timer (
        .clk(clk),
        .rstn(rstn),
        .start(timerStart),
        .run(state_q == ST_DELAY),
        .done(timerDone)
    );

    ////////////////////////////////////////////////////////////////////////
    // Enable decisions

    logic readyNext; // Ready indication, next cycle
    logic powerNext; // RF driver supply, next cycle
    logic shutterNext; // Shutter open indication, next cycle
    logic oemReady; // OEM ready term, no memory of interlock faults

    // OEM: live combination of inputs and the over-temperature latch, no interlock latch, no delay
    assign oemReady = intlkS && shutReqS && !resetReqS
                      && !otLatch_q && strapTaken_q;

    // Shutter status needs the switch and the request together
    assign shutterNext = shutSwS && shutReqS;

    // Ready: sequencer result or OEM term, always killed by hazards
    always_comb begin
        if (oem_q) begin
            readyNext = oemReady;
        end else begin
            readyNext = state_q == ST_READY;
        end
        if (resetReqS || !intlkS || otLatch_q) begin
            readyNext = 1'b0;
        end
    end

    // Supply also flows during the delay so the driver can settle;
    // it still needs shutter and interlock in every case
    always_comb begin
        if (oem_q) begin
            powerNext = oemReady;
        end else begin
            powerNext = (state_q == ST_DELAY) || (state_q == ST_READY);
        end
        if (!shutterNext || resetReqS || !intlkS || otLatch_q) begin
            powerNext = 1'b0;
        end
        if (!oem_q && state_q == ST_READY && !readyNext) begin
            powerNext = 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Output flops

    // Every pin comes straight from a flop; all open after reset
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            rfPowerEn <= 1'b0;
            readyClosed <= 1'b0;
            readyLamp <= 1'b0;
            shutterClosed <= 1'b0;
            shutter_lamp <= 1'b0;
            interlockOpenClosed <= 1'b0;
        end else begin
            rfPowerEn <= powerNext;
            readyClosed <= readyNext;
            readyLamp <= readyNext;
            shutterClosed <= shutterNext;
            shutter_lamp <= shutterNext;
            interlockOpenClosed <= !intlkS;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Event capture

    logic [EV_W-1:0] events_q; // Sticky event flags
    logic [EV_W-1:0] mask_q; // Interrupt enables
    logic [EV_W-1:0] evSet; // Events seen this cycle
    logic [EV_W-1:0] evClr; // Write-one-clear strobes
    logic intlkPrev_q; // Interlock level last cycle
    logic otPrev_q; // Over-temperature latch last cycle
    logic busWrite; // Completing APB write

    // Edge history for event detection
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            intlkPrev_q <= 1'b0;
            otPrev_q <= 1'b0;
        end else begin
            intlkPrev_q <= intlkS;
            otPrev_q <= otLatch_q;
        end
    end

    always_comb begin
        evSet = '0;
        evSet[EV_INTERLOCK] = intlkPrev_q && !intlkS;
        evSet[EV_OVERTEMP] = otLatch_q && !otPrev_q;
        evSet[EV_READY_ON] = readyNext && !readyClosed;
        evSet[EV_READY_OFF] = !readyNext && readyClosed;
    end

    assign evClr = (busWrite && paddr == ADDR_EVENT) ?
                   pwdata[EV_W-1:0] : '0;

    // A set in the same cycle as its clear wins, so no event is lost
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            events_q <= '0;
        end else begin
            events_q <= (events_q & ~evClr) | evSet;
        end
    end

    // Level interrupt while any enabled flag is pending
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            irq <= 1'b0;
        end else begin
            irq <= |(((events_q & ~evClr) | evSet) & mask_q);
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // APB slave

    logic [31:0] readMux; // Read data chosen at setup
    logic addrOk; // Address maps to a register
    logic setupPhase; // First cycle of a transfer

    assign setupPhase = psel && !penable;
    assign busWrite = psel && penable && pready && pwrite;
    assign addrOk = (paddr == ADDR_STATUS) || (paddr == ADDR_EVENT) ||
                    (paddr == ADDR_MASK);

    // Status word shows the block's own live state
    always_comb begin
        readMux = '0;
        case (paddr)
            ADDR_STATUS: begin
                readMux = {20'h00000, oem_q, otLatch_q, timerDone,
                           state_q, interlockOpenClosed, shutter_lamp,
                           rfPowerEn, readyClosed, intlkS, shutReqS,
                           keyOnS};
            end
            ADDR_EVENT: begin
                readMux = {28'h0000000, events_q};
            end
            ADDR_MASK: begin
                readMux = {28'h0000000, mask_q};
            end
            default: begin
                readMux = '0;
            end
        endcase
    end

    // Zero wait states: ready rises for the access cycle only
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            pready <= 1'b0;
            prdata <= '0;
            pslverr <= 1'b0;
        end else begin
            pready <= setupPhase;
            prdata <= (setupPhase && !pwrite) ? readMux : '0;
            pslverr <= setupPhase && !addrOk;
        end
    end

    // Mask register; the only plain read/write storage
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            mask_q <= MASK_RESET;
        end else if (busWrite && paddr == ADDR_MASK) begin
            mask_q <= pwdata[EV_W-1:0];
        end
    end
endmodule : laser_enable_sequencer

// File: rtl/laser_seq_pkg.sv
package laser_seq_pkg;
    ////////////////////////////////////////////////////////////////////////
    // Clock and delay timing
    localparam int unsigned CLK_FREQ_KHZ = 100000; // 100 MHz system clock
    localparam int unsigned ARM_DELAY_MS = 5000; // Five-second enable delay
    // Delay in clock cycles, used as the top-level parameter default
    localparam int unsigned ARM_DELAY_CYCLES = ARM_DELAY_MS * CLK_FREQ_KHZ;
    localparam int unsigned TIMER_W = 32; // Wide enough for 500e6 cycles
    localparam int unsigned SYNC_W = 7; // Number of synchronised inputs

    ////////////////////////////////////////////////////////////////////////
    // Register map, byte addresses
    localparam logic [7:0] ADDR_STATUS = 8'h00; // Live state, read only
    localparam logic [7:0] ADDR_EVENT = 8'h04; // Sticky events, write 1 clear
    localparam logic [7:0] ADDR_MASK = 8'h08; // Interrupt enables

    ////////////////////////////////////////////////////////////////////////
    // Event bit positions, shared by the event and mask registers
    localparam int unsigned EV_INTERLOCK = 0; // Interlock opened
    localparam int unsigned EV_OVERTEMP = 1; // Over-temperature latched
    localparam int unsigned EV_READY_ON = 2; // Ready became active
    localparam int unsigned EV_READY_OFF = 3; // Ready dropped
    localparam int unsigned EV_W = 4; // Event register width
    localparam logic [EV_W-1:0] MASK_RESET = 4'h0; // All masked after reset

    ////////////////////////////////////////////////////////////////////////
    // Keyswitch-variant sequencer states
    typedef enum logic [1:0] {
        ST_LOCKED = 2'b00, // Fault or power-up, waiting for a reset action
        ST_ARMED = 2'b01, // Reset action seen, waiting for its release
        ST_DELAY = 2'b10, // RF powered, counting the enable delay
        ST_READY = 2'b11 // Lasing possible
    } seq_state_e;
endpackage : laser_seq_pkg

// File: verification/laser_enable_sequencer_tb_top.sv
`timescale 1ns/100ps
module laser_enable_sequencer_tb_top;
    import laser_seq_pkg::*;
    localparam int unsigned DLY = 20; // Short enable delay
    localparam logic [5:0] OK = 6'h2e; // Key, switch, request, interlock
    logic clk = 1'b0;
    logic rstn = 1'b0;
    logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0, oemMode = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0, prdata, rd;
    logic pready, pslverr, err;
    logic keyOn, resetRequest, shutterSwitchOpen, shutterRequest;
    logic interlockClosed, overTemp, rfPowerEn, readyClosed, readyLamp;
    logic shutterClosed, shutter_lamp, interlockOpenClosed, irq;
    int n_mismatch = 0, check_count = 0, n;
    initial begin
        forever #5 clk = ~clk;
    end
    laser_enable_sequencer #(.DELAY_CYCLES(DLY)) DUT (.clk(clk),
        .rstn(rstn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .oemMode(oemMode), .keyOn(keyOn),
        .resetRequest(resetRequest), .shutterSwitchOpen(shutterSwitchOpen),
        .shutterRequest(shutterRequest), .interlockClosed(interlockClosed),
        .overTemp(overTemp), .rfPowerEn(rfPowerEn),
        .readyClosed(readyClosed), .readyLamp(readyLamp),
        .shutterClosed(shutterClosed), .shutter_lamp(shutter_lamp),
        .interlockOpenClosed(interlockOpenClosed), .irq(irq));
    plc_model plc (.clk(clk), .keyOn(keyOn), .resetRequest(resetRequest),
        .shutterSwitchOpen(shutterSwitchOpen),
        .shutterRequest(shutterRequest), .interlockClosed(interlockClosed),
        .overTemp(overTemp));
    ////////////////////////////////////////////////////////////////////////
    // Compare and count; four-state so unknown never matches
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        check_count++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("BAD %0t seen %h expected %h", $time, seen, exp);
        end
    endtask : chk
    // One APB transfer; waits on pready, no assumed latency
    task automatic apb(input logic wr, input logic [7:0] a,
        input logic [31:0] d);
        @(posedge clk);
        {psel, pwrite, penable} <= {1'b1, wr, 1'b0};
        {paddr, pwdata} <= {a, d};
        @(posedge clk);
        penable <= 1'b1;
        @(posedge clk);
        while (pready !== 1'b1) @(posedge clk);
        {rd, err} = {prdata, pslverr};
        {psel, penable} <= 2'b00;
    endtask : apb
    // Three-edge input latency plus margin
    task automatic settle;
        repeat (5) @(posedge clk);
    endtask : settle
    task automatic doReset(input logic oem);
        @(posedge clk);
        {rstn, oemMode} <= {1'b0, oem};
        repeat (6) @(posedge clk);
        rstn <= 1'b1;
        repeat (3) @(posedge clk);
    endtask : doReset
    // Bounded wait for ready; n holds the edges spent
    task automatic waitRdy(input int lim);
        n = 0;
        while (readyClosed !== 1'b1 && n < lim) begin
            @(posedge clk);
            n++;
        end
    endtask : waitRdy
    task automatic report_and_stop;
        $display("checks %0d mismatches %0d", check_count, n_mismatch);
        if (n_mismatch == 0 && check_count > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask : report_and_stop
    ////////////////////////////////////////////////////////////////////////
    // Run is a few hundred cycles; this limit only catches a hang
    initial begin
        repeat (5000) @(posedge clk);
        n_mismatch++;
        report_and_stop();
    end
    initial begin
        plc.drive(OK);
        doReset(1'b0);
        repeat (DLY + 10) @(posedge clk);
        chk(rfPowerEn, 0);
        chk(readyClosed, 0);
        apb(1'b0, ADDR_STATUS, 32'h0);
        chk(rd[8:7], 2'h0);
        chk(rd[11], 0);
        chk({shutterClosed, shutter_lamp}, 2'h3);
        $display("test powerup lock done");
        plc.pulseStart(OK | 6'h10);
        settle();
        chk(rfPowerEn, 0);
        plc.drive(OK);
        settle();
        chk({rfPowerEn, readyClosed}, 2'h2);
        waitRdy(DLY * 2);
        chk(n >= DLY, 1);
        chk({readyClosed, readyLamp}, 2'h3);
        $display("test remote start done");
        apb(1'b1, ADDR_EVENT, 32'hf);
        apb(1'b1, ADDR_MASK, 32'h1);
        plc.drive(6'h2c);
        settle();
        chk({rfPowerEn, readyClosed, interlockOpenClosed}, 3'h1);
        chk(irq, 1);
        plc.drive(OK);
        repeat (DLY + 10) @(posedge clk);
        chk(readyClosed, 0);
        apb(1'b0, ADDR_EVENT, 32'h0);
        chk(rd[0], 1);
        apb(1'b1, ADDR_EVENT, 32'h1);
        repeat (2) @(posedge clk);
        chk(irq, 0);
        apb(1'b0, 8'h0c, 32'h0);
        chk({err, rd}, {1'b1, 32'h0});
        $display("test interlock latch done");
        plc.keyToggle(OK);
        waitRdy(DLY * 3);
        chk(readyClosed, 1);
        plc.drive(6'h2a);
        settle();
        chk({rfPowerEn, shutterClosed, shutter_lamp}, 3'h0);
        $display("test key toggle done");
        plc.drive(OK);
        doReset(1'b1);
        waitRdy(10);
        chk({readyClosed, rfPowerEn}, 2'h3);
        apb(1'b0, ADDR_STATUS, 32'h0);
        chk(rd[11], 1);
        plc.drive(6'h2c);
        settle();
        chk(readyClosed, 0);
        plc.drive(OK);
        waitRdy(8);
        chk(readyClosed, 1);
        plc.drive(6'h3e);
        settle();
        chk(rfPowerEn, 0);
        plc.drive(OK);
        waitRdy(8);
        chk(readyClosed, 1);
        $display("test oem variant done");
        plc.drive(OK | 6'h01);
        settle();
        plc.drive(OK);
        repeat (10) @(posedge clk);
        chk({rfPowerEn, readyClosed}, 2'h0);
        $display("test overtemp done");
        report_and_stop();
    end
endmodule : laser_enable_sequencer_tb_top

// File: verification/laser_seq_monitor.sv
`timescale 1ns/100ps
module laser_seq_monitor #(
    parameter int unsigned DELAY_CYCLES = 20
) (
    input wire logic clk,
    input wire logic rstn,
    input wire logic oemMode,
    input wire logic resetRequest,
    input wire logic shutterSwitchOpen,
    input wire logic shutterRequest,
    input wire logic interlockClosed,
    input wire logic overTemp,
    input wire logic rfPowerEn,
    input wire logic readyClosed,
    input wire logic readyLamp,
    input wire logic shutterClosed,
    input wire logic shutter_lamp
);
    ////////////////////////////////////////////////////////////////////////
    logic [2:0] upCnt; // Edges since reset release, saturating
    logic otHit; // Over-temperature seen since reset
    logic [31:0] pwrCnt; // Consecutive cycles of driver power
    logic aged; // Synchronisers flushed of reset values
    assign aged = (upCnt >= 3'h4);
    // Helper state; one block keeps the file short
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            upCnt <= 3'h0;
            otHit <= 1'b0;
            pwrCnt <= 32'h0;
        end else begin
            upCnt <= aged ? upCnt : upCnt + 3'h1;
            otHit <= otHit | overTemp;
            pwrCnt <= !rfPowerEn ? 32'h0 : pwrCnt + 32'h1;
        end
    end
    ////////////////////////////////////////////////////////////////////////
    // Latched over-temperature silences the live-input checks
    default clocking @(posedge clk); endclocking
    default disable iff (!rstn || otHit);
    sequence holdReq;
        resetRequest [*4];
    endsequence
    sequence ilOpen;
        (!interlockClosed) [*4];
    endsequence
    sequence oemOk;
        (aged && oemMode && interlockClosed && shutterRequest &&
            !resetRequest && !overTemp) [*4];
    endsequence
    a_ready_lamp_pair: assert property (readyClosed == readyLamp)
        else $error("ready lamp differs from ready output");
    a_shut_lamp_pair: assert property (shutterClosed == shutter_lamp)
        else $error("shutter lamp differs from shutter output");
    a_reset_inhibit: assert property (holdReq |=> !rfPowerEn)
        else $error("driver powered while start request held");
    a_shutter_follows: assert property (aged |-> shutterClosed ==
        $past(shutterSwitchOpen && shutterRequest, 3))
        else $error("shutter output not switch and request");
    a_interlock_cut: assert property (ilOpen |=>
        !rfPowerEn && !readyClosed)
        else $error("power or ready kept with interlock open");
    a_power_shutter: assert property (rfPowerEn |-> shutterClosed)
        else $error("driver powered without shutter open");
    a_oem_immediate: assert property (oemOk |=> readyClosed)
        else $error("oem variant not ready with inputs good");
    a_enable_delay: assert property ($rose(readyClosed) &&
        !oemMode |-> pwrCnt >= DELAY_CYCLES)
        else $error("ready rose before the enable delay");
    a_overtemp_hold: assert property (@(posedge clk) disable iff (!rstn)
        otHit && $past(otHit, 4) |-> !rfPowerEn && !readyClosed)
        else $error("outputs active after over-temperature");
endmodule : laser_seq_monitor

bind laser_enable_sequencer laser_seq_monitor #(
    .DELAY_CYCLES(DELAY_CYCLES)
) mon (.clk(clk), .rstn(rstn), .oemMode(oemMode),
    .resetRequest(resetRequest), .shutterSwitchOpen(shutterSwitchOpen),
    .shutterRequest(shutterRequest), .interlockClosed(interlockClosed),
    .overTemp(overTemp), .rfPowerEn(rfPowerEn), .readyClosed(readyClosed),
    .readyLamp(readyLamp), .shutterClosed(shutterClosed),
    .shutter_lamp(shutter_lamp));

// File: verification/plc_model.sv
`timescale 1ns/100ps
// Machine controller: slow levels, bit order key,req,sw,shreq,il,ot
module plc_model (
    input wire logic clk,
    output logic keyOn,
    output logic resetRequest,
    output logic shutterSwitchOpen,
    output logic shutterRequest,
    output logic interlockClosed,
    output logic overTemp
);
    // Everything idle and unsafe at time zero
    initial begin
        {keyOn, resetRequest, shutterSwitchOpen} = 3'h0;
        {shutterRequest, interlockClosed, overTemp} = 3'h0;
    end
    ////////////////////////////////////////////////////////////////////////
    // Levels change just after an edge, never mid-cycle
    task automatic drive(input logic [5:0] v);
        @(posedge clk);
        {keyOn, resetRequest, shutterSwitchOpen, shutterRequest,
            interlockClosed, overTemp} <= v;
    endtask : drive
    // Momentary start pulse, long enough to pass the synchronisers
    task automatic pulseStart(input logic [5:0] base);
        drive(base | 6'h10);
        repeat (4) @(posedge clk);
        drive(base);
    endtask : pulseStart
    // Operator turns the key off then on again
    task automatic keyToggle(input logic [5:0] base);
        drive(base & 6'h1f);
        repeat (4) @(posedge clk);
        drive(base);
    endtask : keyToggle
endmodule : plc_model
